// ### inc/bank_cmp_pkg.sv
package bank_cmp_pkg;

  // Register addresses on the five-bit register port.
  localparam logic [4:0] ADDR_NONINV_SEL = 5'h03;
  localparam logic [4:0] ADDR_INV_SEL    = 5'h04;
  localparam logic [4:0] ADDR_THRESH     = 5'h0b;
  localparam logic [4:0] ADDR_BANK_CTL   = 5'h0c;
  localparam logic [4:0] ADDR_CMP_STATUS = 5'h0d;

  // Field positions of both channel-select registers; RETURN_SEL is in the inverting one only.
  localparam int POS_LSB       = 0;
  localparam int POS_MSB       = 2;
  localparam int BANK_LSB      = 3;
  localparam int BANK_MSB      = 5;
  localparam int RETURN_SEL    = 6;

  // Field positions in the bank control register.
  localparam int GROUP_LSB     = 0;
  localparam int GROUP_MSB     = 2;
  localparam int BANK_SWITCH   = 3;

  // Geometry of the input multiplexer.
  localparam int NUM_BANKS     = 8;
  localparam int BANK_SIZE     = 8;
  localparam int CODE_W        = 3;
  localparam int CHAN_W        = 6;

  // Reset values.
  localparam logic [7:0] RST_NONINV_SEL = 8'h00;
  localparam logic [7:0] RST_INV_SEL    = 8'h00;
  localparam logic [7:0] RST_THRESH     = 8'h00;
  localparam logic [7:0] RST_BANK_CTL   = 8'h00;

  // Writable bits; the rest read as zero.
  localparam logic [7:0] MASK_NONINV_SEL = 8'h3f;
  localparam logic [7:0] MASK_INV_SEL    = 8'h7f;
  localparam logic [7:0] MASK_BANK_CTL   = 8'h0f;

endpackage

// ### logic/comparator_route.sv
`timescale 1ns/10ps
module comparator_route (
  input  wire logic [7:0]  noninv_sel_i,
  input  wire logic [7:0]  inv_sel_i,
  input  wire logic [7:0]  bank_ctl_i,
  output logic      [47:0] chan_map_o,
  output logic      [5:0]  amp_noninv_ch_o,
  output logic      [5:0]  amp_inv_ch_o
);

  logic       group_mode;
  logic [2:0] group_code;
  logic [2:0] noninv_bank;
  logic [2:0] inv_bank;
  logic [2:0] noninv_pos;
  logic [2:0] inv_pos;

  assign group_mode  = bank_ctl_i[bank_cmp_pkg::BANK_SWITCH];
  assign group_code  = bank_ctl_i[bank_cmp_pkg::GROUP_MSB:bank_cmp_pkg::GROUP_LSB];
  assign noninv_bank = noninv_sel_i[bank_cmp_pkg::BANK_MSB:bank_cmp_pkg::BANK_LSB];
  assign inv_bank    = inv_sel_i[bank_cmp_pkg::BANK_MSB:bank_cmp_pkg::BANK_LSB];
  assign noninv_pos  = noninv_sel_i[bank_cmp_pkg::POS_MSB:bank_cmp_pkg::POS_LSB];
  assign inv_pos     = inv_sel_i[bank_cmp_pkg::POS_MSB:bank_cmp_pkg::POS_LSB];

  // In group mode the amplifier position is forced to the group code.
  assign amp_noninv_ch_o = {group_mode ? group_code : noninv_pos, noninv_bank};
  assign amp_inv_ch_o    = {group_mode ? group_code : inv_pos, inv_bank};

  // Bank n carries every eighth input starting at input n, so a channel index
  // is the position above the bank; a consecutive group is then one position.
  genvar n;
  generate
    for (n = 0; n < bank_cmp_pkg::NUM_BANKS; n++) begin : g_bank
      localparam logic [2:0] BANK = 3'(n);
      logic [2:0] pos;
      always_comb begin
        // Shared group code picks the same position per bank.
        if (group_mode) begin
          pos = group_code;
        // Non-inverting select owns its bank; it wins a tie.
        end else if (noninv_bank == BANK) begin
          pos = noninv_pos;
        // Inverting select feeds its bank, also when the return pin is used.
        end else if (inv_bank == BANK) begin
          pos = inv_pos;
        // Unassigned bank n falls back to channel n.
        end else begin
          pos = 3'h0;
        end
      end
      // Comparator n only ever sees bank n, so no input is routed twice.
      assign chan_map_o[n*6 +: 6] = {pos, BANK};
    end
  endgenerate

endmodule

// ### logic/bank_comparator_select.sv
`timescale 1ns/10ps
module bank_comparator_select (
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic [4:0]  ADDR_I,
  input  wire logic [7:0]  WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  input  wire logic [7:0]  CMP_I,
  output logic      [7:0]  RDATA_O,
  output logic      [7:0]  THRESH_CODE_O,
  output logic      [47:0] CMP_CHAN_O,
  output logic      [5:0]  AMP_NONINV_CH_O,
  output logic      [5:0]  AMP_INV_CH_O,
  output logic             RETURN_PIN_SELECT_O,
  output logic             BANK_SWITCH_SELECT_O
);

  typedef struct packed {
    logic [7:0]  noninv_sel;
    logic [7:0]  inv_sel;
    logic [7:0]  bank_ctl;
    logic [7:0]  thresh;
    logic [7:0]  rdata;
    logic [7:0]  cmp_meta;
    logic [7:0]  cmp_sync;
    logic [47:0] chan;
    logic [5:0]  amp_noninv;
    logic [5:0]  amp_inv;
    logic        ret_sel;
  } state_s;

  state_s      st;
  state_s      next_st;
  logic [47:0] route_chan;
  logic [5:0]  route_noninv;
  logic [5:0]  route_inv;

  comparator_route u_route (
    .noninv_sel_i    (st.noninv_sel),
    .inv_sel_i       (st.inv_sel),
    .bank_ctl_i      (st.bank_ctl),
    .chan_map_o      (route_chan),
    .amp_noninv_ch_o (route_noninv),
    .amp_inv_ch_o    (route_inv)
  );

  always_comb begin
    next_st = st;
    // Comparator levels are asynchronous to the clock, so they pass two flops.
    next_st.cmp_meta = CMP_I;
    next_st.cmp_sync = st.cmp_meta;
    next_st.chan       = route_chan;
    next_st.amp_noninv = route_noninv;
    next_st.amp_inv    = route_inv;
    // Return pin select follows inverting bit 6.
    next_st.ret_sel    = st.inv_sel[bank_cmp_pkg::RETURN_SEL];
    if (WR_I) begin
      case (ADDR_I)
        bank_cmp_pkg::ADDR_NONINV_SEL: begin
          next_st.noninv_sel = WDATA_I & bank_cmp_pkg::MASK_NONINV_SEL;
        end
        bank_cmp_pkg::ADDR_INV_SEL: begin
          next_st.inv_sel = WDATA_I & bank_cmp_pkg::MASK_INV_SEL;
        end
        // One threshold code for every comparator.
        bank_cmp_pkg::ADDR_THRESH: begin
          next_st.thresh = WDATA_I;
        end
        // Switch bit chooses group or individual control.
        bank_cmp_pkg::ADDR_BANK_CTL: begin
          next_st.bank_ctl = WDATA_I & bank_cmp_pkg::MASK_BANK_CTL;
        end
        default: begin
          next_st.thresh = st.thresh;
        end
      endcase
    end
    if (RD_I) begin
      case (ADDR_I)
        bank_cmp_pkg::ADDR_NONINV_SEL: next_st.rdata = st.noninv_sel;
        bank_cmp_pkg::ADDR_INV_SEL:    next_st.rdata = st.inv_sel;
        bank_cmp_pkg::ADDR_THRESH:     next_st.rdata = st.thresh;
        bank_cmp_pkg::ADDR_BANK_CTL:   next_st.rdata = st.bank_ctl;
        // Status returns the synchronized levels, taken from CMP_I two clocks before the read.
        bank_cmp_pkg::ADDR_CMP_STATUS: next_st.rdata = st.cmp_sync;
        default:                       next_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      st            <= '0;
      st.noninv_sel <= bank_cmp_pkg::RST_NONINV_SEL;
      st.inv_sel    <= bank_cmp_pkg::RST_INV_SEL;
      st.bank_ctl   <= bank_cmp_pkg::RST_BANK_CTL;
      st.thresh     <= bank_cmp_pkg::RST_THRESH;
    end else begin
      st <= next_st;
    end
  end

  assign RDATA_O              = st.rdata;
  assign THRESH_CODE_O        = st.thresh;
  assign CMP_CHAN_O           = st.chan;
  assign AMP_NONINV_CH_O      = st.amp_noninv;
  assign AMP_INV_CH_O         = st.amp_inv;
  assign RETURN_PIN_SELECT_O  = st.ret_sel;
  assign BANK_SWITCH_SELECT_O = st.bank_ctl[bank_cmp_pkg::BANK_SWITCH];

  // Helper views of the register fields, one step ahead of the registered routing.
  logic       grp;
  logic [2:0] gcode;
  logic [2:0] nb;
  logic [2:0] ib;
  assign grp   = st.bank_ctl[bank_cmp_pkg::BANK_SWITCH];
  assign gcode = st.bank_ctl[bank_cmp_pkg::GROUP_MSB:bank_cmp_pkg::GROUP_LSB];
  assign nb    = st.noninv_sel[bank_cmp_pkg::BANK_MSB:bank_cmp_pkg::BANK_LSB];
  assign ib    = st.inv_sel[bank_cmp_pkg::BANK_MSB:bank_cmp_pkg::BANK_LSB];

  // Each comparator must sit on its own bank; that alone keeps the
  // eight routed inputs distinct in both modes.
  logic [7:0] own_bank;
  genvar k;
  generate
    for (k = 0; k < bank_cmp_pkg::NUM_BANKS; k++) begin : g_own
      assign own_bank[k] = CMP_CHAN_O[k*6 +: 3] == 3'(k);
    end
  endgenerate

  a_status_sample: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    RD_I && ADDR_I == bank_cmp_pkg::ADDR_CMP_STATUS |=> RDATA_O == $past(st.cmp_sync))
    else $error("status read did not return the sampled comparators");

  a_thresh_write: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    WR_I && ADDR_I == bank_cmp_pkg::ADDR_THRESH |=> THRESH_CODE_O == $past(WDATA_I))
    else $error("threshold code not taken from write");

  a_group_first: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    grp && $stable(st.bank_ctl) |=> CMP_CHAN_O[5:0] == {$past(gcode), 3'h0})
    else $error("group mode first comparator channel wrong");

  a_group_shared: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    grp |=> CMP_CHAN_O[44:42] == 3'h7 && CMP_CHAN_O[47:45] == CMP_CHAN_O[5:3])
    else $error("group mode banks do not share one position");

  a_group_order: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    grp |=> CMP_CHAN_O[11:6] == {$past(gcode), 3'h1})
    else $error("group code does not map to ascending group");

  a_monitor_group: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    grp |=> AMP_NONINV_CH_O[5:3] == $past(gcode) && AMP_INV_CH_O[5:3] == $past(gcode))
    else $error("monitor left the preselected group");

  a_noninv_bank: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !grp |=> CMP_CHAN_O[$past(nb)*6 +: 6] == {$past(st.noninv_sel[2:0]), $past(nb)})
    else $error("non-inverting bank comparator not on selected channel");

  a_inv_bank: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !grp && nb != ib |=> CMP_CHAN_O[$past(ib)*6 +: 6] == {$past(st.inv_sel[2:0]), $past(ib)})
    else $error("inverting bank comparator not on selected channel");

  a_fixed_bank: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !grp && nb != 3'h7 && ib != 3'h7 |=> CMP_CHAN_O[47:42] == 6'h07)
    else $error("unassigned bank not on its fixed channel");

  a_return_pin: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    WR_I && ADDR_I == bank_cmp_pkg::ADDR_INV_SEL |-> ##2 RETURN_PIN_SELECT_O == $past(WDATA_I[6], 2))
    else $error("return pin select does not follow bit 6");

  a_distinct_banks: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    RST_N_I |=> own_bank == 8'hff)
    else $error("a comparator is routed outside its own bank");

endmodule

// ### dv/host_model.sv
`timescale 1ns/10ps
module host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic      [4:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o,
  output logic            rd_o
);
  initial begin
    addr_o = 5'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // Released lines show the inverse so a stale value can never pass.
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
  endtask
endmodule

// ### dv/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic        clk;
  logic        rst_n;
  logic [4:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  cmp;
  logic [7:0]  rdata;
  logic [7:0]  thr;
  logic [47:0] chan;
  logic [5:0]  ampn;
  logic [5:0]  ampi;
  logic        retp;
  logic        bsw;
  logic [7:0]  n, v, c, r, x;
  int          num_errors;
  int          compares;
  int          seed;
  bank_comparator_select dut_u (.CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .CMP_I(cmp), .RDATA_O(rdata), .THRESH_CODE_O(thr),
    .CMP_CHAN_O(chan), .AMP_NONINV_CH_O(ampn), .AMP_INV_CH_O(ampi),
    .RETURN_PIN_SELECT_O(retp), .BANK_SWITCH_SELECT_O(bsw));
  host_model host_u (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Bank b holds every eighth input, so position p of bank b is input 8p+b.
  function automatic logic [5:0] ch(input logic [2:0] b, input logic [2:0] p);
    return {p, b};
  endfunction
  function automatic logic [47:0] emap(input logic [7:0] n, input logic [7:0] v,
                                       input logic [7:0] c);
    logic [47:0] m;
    for (int b = 0; b < 8; b++) m[6*b+:6] = ch(3'(b), c[3] ? c[2:0] : 3'h0);
    if (!c[3]) begin
      m[6*v[5:3]+:6] = ch(v[5:3], v[2:0]);
      m[6*n[5:3]+:6] = ch(n[5:3], n[2:0]);
    end
    return m;
  endfunction
  task automatic end_sim;
    $display("compares %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #400000;
    num_errors++;
    end_sim();
  end
  initial begin
    seed = 32'h08e0fff9;
    rst_n = 1'b0;
    cmp = 8'h00;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    chk(chan, '0);
    chk({18'h0, thr, ampn, ampi, retp, bsw, rdata}, '0);
    repeat (2) @(negedge clk);
    chk(chan, emap(8'h00, 8'h00, 8'h00));
    host_u.rd(bank_cmp_pkg::ADDR_NONINV_SEL, r);
    chk(r, bank_cmp_pkg::RST_NONINV_SEL);
    $display("test reset done");
    x = 8'($random(seed));
    host_u.wr(bank_cmp_pkg::ADDR_THRESH, x);
    chk(thr, x);
    host_u.wr(5'h1f, 8'hff);
    chk(thr, x);
    host_u.rd(5'h1f, r);
    chk(r, 8'h00);
    for (int i = 0; i < 8; i++) begin
      x = (i == 0) ? 8'hff : 8'($random(seed));
      cmp = x;
      repeat (3) @(negedge clk);
      host_u.rd(bank_cmp_pkg::ADDR_CMP_STATUS, r);
      chk(r, x);
      cmp = ~x;
      repeat (2) @(negedge clk);
      chk(rdata, x);
    end
    $display("test status done");
    for (int i = 0; i < 64; i++) begin
      n = 8'($random(seed));
      v = 8'($random(seed));
      c = 8'($random(seed));
      // First a sweep of every group code, then forced shared banks.
      if (i < 8) c[3:0] = 4'(8 + i);
      else if (i < 16) {c[3], v[5:3]} = {1'b0, n[5:3]};
      host_u.wr(bank_cmp_pkg::ADDR_NONINV_SEL, n);
      host_u.wr(bank_cmp_pkg::ADDR_INV_SEL, v);
      host_u.wr(bank_cmp_pkg::ADDR_BANK_CTL, c);
      @(negedge clk);
      chk(chan, emap(n, v, c));
      chk(ampn, ch(n[5:3], c[3] ? c[2:0] : n[2:0]));
      chk(ampi, ch(v[5:3], c[3] ? c[2:0] : v[2:0]));
      chk({retp, bsw}, {v[6], c[3]});
      host_u.rd(bank_cmp_pkg::ADDR_INV_SEL, r);
      chk(r, v & bank_cmp_pkg::MASK_INV_SEL);
      host_u.rd(bank_cmp_pkg::ADDR_BANK_CTL, r);
      chk(r, c & bank_cmp_pkg::MASK_BANK_CTL);
    end
    host_u.rd(bank_cmp_pkg::ADDR_NONINV_SEL, r);
    chk(r, n & bank_cmp_pkg::MASK_NONINV_SEL);
    $display("test routing done");
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk(chan, '0);
    chk({18'h0, thr, ampn, ampi, retp, bsw, rdata}, '0);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk(chan, emap(8'h00, 8'h00, 8'h00));
    host_u.rd(bank_cmp_pkg::ADDR_BANK_CTL, r);
    chk(r, bank_cmp_pkg::RST_BANK_CTL);
    host_u.rd(bank_cmp_pkg::ADDR_INV_SEL, r);
    chk(r, bank_cmp_pkg::RST_INV_SEL);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule
